// ===== bsc_consts.vh
// Constants for the brushless speed and commutation core.
// Assumes a single 125 MHz reference clock and a 32-bit classic Wishbone bus.
`ifndef BSC_CONSTS_VH
`define BSC_CONSTS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define BSC_ADDR_W          8
`define BSC_REG_CTRL        8'h00
`define BSC_REG_STATUS      8'h04
`define BSC_REG_PERIOD      8'h08
`define BSC_REG_DUTY        8'h0C
`define BSC_REG_PHASE       8'h10

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define BSC_CTRL_W          9
`define BSC_CTRL_RST        9'h0FF
`define BSC_CTRL_MAX_MSB    7
`define BSC_CTRL_MAX_LSB    0
`define BSC_CTRL_HALT_BIT   8

// ----------------------------------------------------------------
// Speed reference and discriminator
// ----------------------------------------------------------------
`define BSC_REF_DIV         8192
`define BSC_REF_W           13
`define BSC_PER_W           16
`define BSC_PER_MAX         16'hFFFF
`define BSC_PER_TARGET      16'h4000
`define BSC_LOCK_BAND       16'h0400
`define BSC_SPD_SHIFT       6
`define BSC_PH_SHIFT        9
`define BSC_ERR_W           18

// ----------------------------------------------------------------
// Drive
// ----------------------------------------------------------------
`define BSC_DUTY_W          8
`define BSC_DUTY_START      8'hFF
`define BSC_DUTY_ZERO       8'h00

`endif

// ===== bsc_pwm.v
// Lower-side chopper: free-running carrier compared against the on-duty.
// Assumes the duty input is stable over a carrier period or changes glitch-free.
`timescale 1ns/100ps
`include "bsc_consts.vh"

module bsc_pwm (
    // Clock and reset
    input  wire                    i_clk,
    input  wire                    i_rst,
    // Duty and stop
    input  wire [`BSC_DUTY_W-1:0]  i_duty,
    input  wire                    i_halt,
    // Chop enable
    output reg                     o_chop
);

// ----------------------------------------------------------------
// Carrier
// ----------------------------------------------------------------
reg [`BSC_DUTY_W-1:0] cnt_q;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        cnt_q  <= `BSC_DUTY_ZERO;
        o_chop <= 1'b0;
    end else begin
        cnt_q  <= cnt_q + 8'h01;
        // Full duty never reaches 100 %: one carrier slot stays off
        o_chop <= ~i_halt && (cnt_q < i_duty);
    end
end

endmodule // bsc_pwm

// ===== bsc_ctrl.v
// Digital core of a three-phase brushless driver: Hall decode, six-step
// commutation, speed discriminator plus phase comparator, lower-side PWM.
// Assumes all pin inputs are synchronous to i_clk, which is the reference
// oscillator itself, and a classic Wishbone master on the register port.
//
// Notes on behaviour
// - A low run input means run and a high one halt; an open pin reads high.
// - A low direction input selects forward and a high one reverse; open reads high.
// - Each Hall channel is high when its positive input exceeds its negative one.
// - Speed and phase errors are summed into one drive correction.
// - The speed deviation is refreshed once every two tach cycles.
// - The phase deviation is refreshed on every tach cycle.
// - The target tach frequency is the clock divided by 8192.
// - Drive power is set only by the PWM on-duty from the correction.
// - Only the lower switch chops; the upper switch holds the whole step.
// - Lock output is low within 6.25 percent; outside, duty moves with the error.
// - A tach-input power-on reset clears Hall, divider and discriminator state but keeps the period and control registers.
// - Halt puts the core in a low-power state with drive off and the reference and period counters cleared; the PWM carrier keeps running.
`timescale 1ns/100ps
`include "bsc_consts.vh"

module bsc_ctrl (
    // Clock and reset
    input  wire                    i_clk,
    input  wire                    i_rst,
    input  wire                    i_tach_por,
    // Wishbone slave
    input  wire                    i_wb_cyc,
    input  wire                    i_wb_stb,
    input  wire                    i_wb_we,
    input  wire [`BSC_ADDR_W-1:0]  i_wb_adr,
    input  wire [3:0]              i_wb_sel,
    input  wire [31:0]             i_wb_dat,
    output reg                     o_wb_ack,
    output reg  [31:0]             o_wb_dat,
    // Control pins
    input  wire                    i_run_halt_n,
    input  wire                    i_dir_rev,
    // Hall comparator inputs
    input  wire [7:0]              i_hall_a_pos,
    input  wire [7:0]              i_hall_a_neg,
    input  wire [7:0]              i_hall_b_pos,
    input  wire [7:0]              i_hall_b_neg,
    input  wire [7:0]              i_hall_c_pos,
    input  wire [7:0]              i_hall_c_neg,
    // Tachometer
    input  wire                    i_tach_pulse,
    // Drive outputs, bit 0 phase A
    output reg  [2:0]              o_hi_on,
    output reg  [2:0]              o_lo_on,
    // Status pins
    output reg                     o_speed_lock_indicator_n,
    output reg                     o_low_power
);

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
// Six-step table: returns {upper[2:0], lower[2:0]}, reversed by swapping sides
function [5:0] commutate;
    input [2:0] hall;
    input       rev;
    reg   [5:0] fwd;
    begin
        case (hall)
            3'h5:    fwd = {3'h1, 3'h2};
            3'h4:    fwd = {3'h1, 3'h4};
            3'h6:    fwd = {3'h2, 3'h4};
            3'h2:    fwd = {3'h2, 3'h1};
            3'h3:    fwd = {3'h4, 3'h1};
            3'h1:    fwd = {3'h4, 3'h2};
            default: fwd = 6'h00;
        endcase
        commutate = rev ? {fwd[2:0], fwd[5:3]} : fwd;
    end
endfunction

// Comparator with hold on equality, standing in for hysteresis
function hall_level;
    input [7:0] pos;
    input [7:0] neg;
    input       prev;
    begin
        if (pos > neg)
            hall_level = 1'b1;
        else if (pos < neg)
            hall_level = 1'b0;
        else
            hall_level = prev;
    end
endfunction

// Adds a signed correction to the duty and clamps it to 0..limit
function [`BSC_DUTY_W-1:0] duty_add;
    input [`BSC_DUTY_W-1:0]        duty;
    input signed [`BSC_ERR_W-1:0]  corr;
    input [`BSC_DUTY_W-1:0]        limit;
    reg   signed [`BSC_ERR_W-1:0]  sum;
    begin
        sum = $signed({10'h000, duty}) + corr;
        if (sum < 0)
            duty_add = `BSC_DUTY_ZERO;
        else if (sum > $signed({10'h000, limit}))
            duty_add = limit;
        else
            duty_add = sum[`BSC_DUTY_W-1:0];
    end
endfunction

// ----------------------------------------------------------------
// Local reset and run state
// ----------------------------------------------------------------
// Tach-input reset is synchronous so the async reset only ever loads constants
wire                   clr = i_tach_por;
reg [`BSC_CTRL_W-1:0]  ctrl_q;
wire                   soft_halt = ctrl_q[`BSC_CTRL_HALT_BIT];
wire [`BSC_DUTY_W-1:0] duty_max  = ctrl_q[`BSC_CTRL_MAX_MSB:`BSC_CTRL_MAX_LSB];
// An open pin floats high through the pad pull-up, so halt is the default
wire                   halt = i_run_halt_n | soft_halt | clr;

// ----------------------------------------------------------------
// Hall decode
// ----------------------------------------------------------------
reg [2:0] hall_q;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        hall_q <= 3'h0;
    end else if (clr) begin
        hall_q <= 3'h0;
    end else begin
        hall_q[0] <= hall_level(i_hall_a_pos, i_hall_a_neg, hall_q[0]);
        hall_q[1] <= hall_level(i_hall_b_pos, i_hall_b_neg, hall_q[1]);
        hall_q[2] <= hall_level(i_hall_c_pos, i_hall_c_neg, hall_q[2]);
    end
end

// ----------------------------------------------------------------
// Reference divider and tach edge
// ----------------------------------------------------------------
reg [`BSC_REF_W-1:0] ref_q;
reg                  tach_q;
wire                 tach_rise = i_tach_pulse & ~tach_q;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        ref_q  <= 13'h0000;
        tach_q <= 1'b0;
    end else begin
        tach_q <= i_tach_pulse;
        // 13-bit wrap gives exactly one reference cycle per 8192 clocks
        if (halt)
            ref_q <= 13'h0000;
        else
            ref_q <= ref_q + 13'h0001;
    end
end

// ----------------------------------------------------------------
// Speed discriminator and phase comparator
// ----------------------------------------------------------------
reg [`BSC_PER_W-1:0]          per_cnt_q;
reg [`BSC_PER_W-1:0]          period_q;
reg                           half_q;
reg signed [`BSC_ERR_W-1:0]   spd_err_q;
reg signed [`BSC_ERR_W-1:0]   ph_err_q;
reg                           locked_q;
reg [`BSC_DUTY_W-1:0]         duty_q;

// Deviation of the two-cycle period from 2 x 8192 clocks, positive when slow
wire signed [`BSC_ERR_W-1:0] spd_dev =
    $signed({2'h0, per_cnt_q}) - $signed({2'h0, `BSC_PER_TARGET});
// Reference count read as signed: positive means the tach edge lags
wire signed [`BSC_ERR_W-1:0] ph_dev =
    {{(`BSC_ERR_W-`BSC_REF_W){ref_q[`BSC_REF_W-1]}}, ref_q};
wire [`BSC_PER_W-1:0] spd_mag = spd_dev[`BSC_ERR_W-1] ?
    (~spd_dev[`BSC_PER_W-1:0] + 16'h0001) : spd_dev[`BSC_PER_W-1:0];
// Band is symmetric: a fast motor locks as readily as a slow one
wire in_band = (spd_mag <= `BSC_LOCK_BAND) &&
    (spd_dev[`BSC_ERR_W-1 -: 2] == 2'h0 || spd_dev[`BSC_ERR_W-1 -: 2] == 2'h3);

wire signed [`BSC_ERR_W-1:0] spd_step = in_band ? 18'sh00000 :
    (spd_dev >>> `BSC_SPD_SHIFT);
wire signed [`BSC_ERR_W-1:0] ph_step  = ph_dev >>> `BSC_PH_SHIFT;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        per_cnt_q <= 16'h0000;
        period_q  <= 16'h0000;
        half_q    <= 1'b0;
        spd_err_q <= 18'sh00000;
        ph_err_q  <= 18'sh00000;
        locked_q  <= 1'b0;
        duty_q    <= `BSC_DUTY_START;
    end else if (halt) begin
        per_cnt_q <= 16'h0000;
        half_q    <= 1'b0;
        spd_err_q <= 18'sh00000;
        ph_err_q  <= 18'sh00000;
        locked_q  <= 1'b0;
        duty_q    <= duty_max;
    end else begin
        if (tach_rise && half_q) begin
            // Second edge closes a two-cycle window
            period_q  <= per_cnt_q;
            spd_err_q <= spd_dev;
            locked_q  <= in_band;
            per_cnt_q <= 16'h0001;
        end else if (per_cnt_q != `BSC_PER_MAX) begin
            per_cnt_q <= per_cnt_q + 16'h0001;
        end
        if (tach_rise) begin
            half_q   <= ~half_q;
            ph_err_q <= ph_dev;
            // Phase term every cycle, speed term every second cycle
            duty_q   <= duty_add(duty_q, (half_q ? spd_step : 18'sh00000) + ph_step,
                                 duty_max);
        end else if (duty_q > duty_max) begin
            duty_q <= duty_max;
        end
    end
end

// ----------------------------------------------------------------
// Chopper and output stage
// ----------------------------------------------------------------
wire       chop;
wire [5:0] pattern = commutate(hall_q, i_dir_rev);

bsc_pwm u_pwm (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_duty (duty_q),
    .i_halt (halt),
    .o_chop (chop)
);

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_hi_on                  <= 3'h0;
        o_lo_on                  <= 3'h0;
        o_speed_lock_indicator_n <= 1'b1;
        o_low_power              <= 1'b1;
    end else begin
        o_low_power              <= halt;
        o_speed_lock_indicator_n <= ~(locked_q & ~halt);
        if (halt) begin
            o_hi_on <= 3'h0;
            o_lo_on <= 3'h0;
        end else begin
            // Upper switch is steady over the step; lower one is gated by the chopper
            o_hi_on <= pattern[5:3];
            o_lo_on <= pattern[2:0] & {3{chop}};
        end
    end
end

// ----------------------------------------------------------------
// Wishbone slave
// ----------------------------------------------------------------
// One wait state; ack drops the cycle after it is given
wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_wb_ack <= 1'b0;
        o_wb_dat <= 32'h00000000;
        ctrl_q   <= `BSC_CTRL_RST;
    end else begin
        o_wb_ack <= wb_req;
        if (wb_req && i_wb_we && i_wb_adr == `BSC_REG_CTRL) begin
            if (i_wb_sel[0])
                ctrl_q[`BSC_CTRL_MAX_MSB:`BSC_CTRL_MAX_LSB] <= i_wb_dat[7:0];
            if (i_wb_sel[1])
                ctrl_q[`BSC_CTRL_HALT_BIT] <= i_wb_dat[`BSC_CTRL_HALT_BIT];
        end
        if (wb_req && !i_wb_we) begin
            case (i_wb_adr)
                `BSC_REG_CTRL:   o_wb_dat <= {23'h000000, ctrl_q};
                `BSC_REG_STATUS: o_wb_dat <= {24'h000000, hall_q, i_dir_rev,
                                              half_q, ~halt, halt, locked_q};
                `BSC_REG_PERIOD: o_wb_dat <= {16'h0000, period_q};
                `BSC_REG_DUTY:   o_wb_dat <= {24'h000000, duty_q};
                `BSC_REG_PHASE:  o_wb_dat <= {{14{ph_err_q[`BSC_ERR_W-1]}}, ph_err_q};
                default:         o_wb_dat <= 32'h00000000;
            endcase
        end
    end
end

// Speed error kept for observation in simulation and future gain tuning
wire unused_spd = ^spd_err_q;

endmodule // bsc_ctrl

// ===== bsc_ctrl_props.sv
// Checker for the brushless core: bus answer, drive pattern, halt and lock timing.
// Assumes it is bound to bsc_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module bsc_ctrl_props (
    // Clock and reset
    input wire       i_clk,
    input wire       i_rst,
    input wire       i_tach_por,
    // Bus
    input wire       i_wb_cyc,
    input wire       i_wb_stb,
    input wire       i_wb_we,
    input wire       o_wb_ack,
    // Pins
    input wire       i_run_halt_n,
    input wire       i_dir_rev,
    input wire [7:0] i_hall_a_pos,
    input wire [7:0] i_hall_a_neg,
    input wire [7:0] i_hall_b_pos,
    input wire [7:0] i_hall_b_neg,
    input wire [7:0] i_hall_c_pos,
    input wire [7:0] i_hall_c_neg,
    input wire       i_tach_pulse,
    input wire [2:0] o_hi_on,
    input wire [2:0] o_lo_on,
    input wire       o_speed_lock_indicator_n,
    input wire       o_low_power
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    wire [50:0] pins_w = {i_hall_a_pos, i_hall_a_neg, i_hall_b_pos, i_hall_b_neg,
                          i_hall_c_pos, i_hall_c_neg, i_dir_rev, i_run_halt_n, i_tach_por};
    reg  [50:0] pins_q;
    reg  [7:0]  steady_q;
    reg  [7:0]  since_tach_q;
    reg         tach_q;
    // A bus write may set the soft halt, so it counts as an input change
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pins_q       <= 51'h0;
            steady_q     <= 8'h00;
            since_tach_q <= 8'hFF;
            tach_q       <= 1'b0;
        end else begin
            pins_q <= pins_w;
            tach_q <= i_tach_pulse;
            if (pins_w != pins_q || (i_wb_cyc && i_wb_we))
                steady_q <= 8'h00;
            else if (steady_q != 8'hFF)
                steady_q <= steady_q + 8'h01;
            if (i_tach_pulse && !tach_q)
                since_tach_q <= 8'h00;
            else if (since_tach_q != 8'hFF)
                since_tach_q <= since_tach_q + 8'h01;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("bus ack held longer than one cycle");
    a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus request not answered in one cycle");
    a_halt_drive_off: assert property (i_run_halt_n [*4] |-> o_hi_on == 3'h0 && o_lo_on == 3'h0)
        else $error("drive active while halted");
    a_halt_low_power: assert property (i_run_halt_n [*4] |-> o_low_power)
        else $error("low power state missing while halted");
    a_por_clears: assert property (i_tach_por [*4] |-> o_hi_on == 3'h0 && o_lo_on == 3'h0)
        else $error("drive active during tach reset");
    a_upper_hold: assert property (steady_q >= 8'h04 |-> $stable(o_hi_on))
        else $error("upper switch changed within a step");
    a_lo_needs_hi: assert property (o_lo_on != 3'h0 |-> o_hi_on != 3'h0 && (o_hi_on & o_lo_on) == 3'h0)
        else $error("lower switch on without a matching upper switch");
    a_one_switch: assert property ($onehot0(o_hi_on) && $onehot0(o_lo_on))
        else $error("more than one switch on a side");
    a_hall_zero_off: assert property (steady_q >= 8'h04 && i_hall_a_pos < i_hall_a_neg
        && i_hall_b_pos < i_hall_b_neg && i_hall_c_pos < i_hall_c_neg |-> o_hi_on == 3'h0)
        else $error("drive on for an all-low hall code");
    a_lock_on_edge: assert property ($fell(o_speed_lock_indicator_n) |-> since_tach_q <= 8'h06)
        else $error("lock asserted away from a tach edge");
endmodule // bsc_ctrl_props

// ===== bsc_motor_model.sv
// Behavioural three-phase motor: Hall levels and a tach square wave.
// Assumes the tach half period is given in clocks; the motor turns only while driven.
`timescale 1ns/100ps
module bsc_motor_model (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // Drive and scenario control
    input  wire [2:0]  i_hi_on,
    input  wire        i_dir_rev,
    input  wire [15:0] i_half,
    input  wire        i_hold,
    input  wire [2:0]  i_code,
    // Sensor outputs
    output wire [7:0]  o_hall_a_pos,
    output wire [7:0]  o_hall_a_neg,
    output wire [7:0]  o_hall_b_pos,
    output wire [7:0]  o_hall_b_neg,
    output wire [7:0]  o_hall_c_pos,
    output wire [7:0]  o_hall_c_neg,
    output reg         o_tach_pulse
);
    reg [15:0] cnt_q;
    reg [2:0]  step_q;
    reg [2:0]  code;
    // Forward Hall order; a held rotor shows the code the bench asks for
    always @* begin
        case (step_q)
            3'h0:    code = 3'h5;
            3'h1:    code = 3'h4;
            3'h2:    code = 3'h6;
            3'h3:    code = 3'h2;
            3'h4:    code = 3'h3;
            default: code = 3'h1;
        endcase
        if (i_hold)
            code = i_code;
    end
    // Sensors swing around a common level and never sit at it
    assign o_hall_a_pos = code[0] ? 8'hA0 : 8'h60;
    assign o_hall_b_pos = code[1] ? 8'hA0 : 8'h60;
    assign o_hall_c_pos = code[2] ? 8'hA0 : 8'h60;
    assign o_hall_a_neg = 8'h80;
    assign o_hall_b_neg = 8'h80;
    assign o_hall_c_neg = 8'h80;
    // Speed comes only from the tach period set here; tach stands when not driven
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q        <= 16'h0000;
            step_q       <= 3'h0;
            o_tach_pulse <= 1'b0;
        end else if (i_hi_on != 3'h0 && !i_hold) begin
            if (cnt_q + 16'h0001 >= i_half) begin
                cnt_q        <= 16'h0000;
                o_tach_pulse <= ~o_tach_pulse;
                if (i_dir_rev)
                    step_q <= (step_q == 3'h0) ? 3'h5 : step_q - 3'h1;
                else
                    step_q <= (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
            end else
                cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule // bsc_motor_model

// ===== testbench.sv
// Self-checking bench for the brushless core with a motor model on its pins.
// Assumes bsc_ctrl, bsc_motor_model and bsc_ctrl_props are compiled before it.
`timescale 1ns/100ps
`include "bsc_consts.vh"
module testbench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         por = 1'b0;
    reg         cyc = 1'b0;
    reg         stb = 1'b0;
    reg         we = 1'b0;
    reg  [7:0]  adr = 8'h00;
    reg  [31:0] wdat = 32'h0;
    reg         run_n = 1'b1;
    reg         rev = 1'b0;
    reg         pin_hold = 1'b1;
    reg  [2:0]  code = 3'h0;
    reg  [15:0] half = 16'h1000;
    reg  [31:0] q;
    wire        ack, lock_n, lowp, tach;
    wire [31:0] rdat;
    wire [2:0]  hi, lo;
    wire [7:0]  ap, an, bp, bn, cp, cn;
    integer     fails = 0;
    integer     n_compared = 0;
    integer     n;
    bsc_ctrl i_bsc_ctrl (.i_clk(clk), .i_rst(rst), .i_tach_por(por),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat), .i_run_halt_n(run_n),
        .i_dir_rev(rev), .i_hall_a_pos(ap), .i_hall_a_neg(an), .i_hall_b_pos(bp),
        .i_hall_b_neg(bn), .i_hall_c_pos(cp), .i_hall_c_neg(cn), .i_tach_pulse(tach),
        .o_hi_on(hi), .o_lo_on(lo), .o_speed_lock_indicator_n(lock_n), .o_low_power(lowp));
    bsc_motor_model i_bsc_motor_model (.i_clk(clk), .i_rst(rst), .i_hi_on(hi),
        .i_dir_rev(rev), .i_half(half), .i_hold(pin_hold), .i_code(code),
        .o_hall_a_pos(ap), .o_hall_a_neg(an), .o_hall_b_pos(bp), .o_hall_b_neg(bn),
        .o_hall_c_pos(cp), .o_hall_c_neg(cn), .o_tach_pulse(tach));
    always #4 clk = ~clk;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input [95:0] name, input [31:0] exp, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    // Classic single cycle; waits for ack, data taken at the ack edge
    task wb(input w, input [7:0] a, input [31:0] d, output [31:0] r);
        integer k;
        begin
            @(posedge clk);
            cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
            k = 0;
            @(posedge clk);
            while (ack !== 1'b1 && k < 100) begin
                @(posedge clk);
                k = k + 1;
            end
            if (k >= 100) fails = fails + 1;
            r = rdat;
            cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        end
    endtask
    function [5:0] fwd_map(input [2:0] c);
        case (c)
            3'h5:    fwd_map = 6'h0A;
            3'h4:    fwd_map = 6'h0C;
            3'h6:    fwd_map = 6'h14;
            3'h2:    fwd_map = 6'h11;
            3'h3:    fwd_map = 6'h21;
            3'h1:    fwd_map = 6'h22;
            default: fwd_map = 6'h00;
        endcase
    endfunction
    task final_report;
        begin
            $display("compared %0d mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        begin
            chk("low power", 32'h1, {31'h0, lowp});
            chk("upper", 32'h0, {29'h0, hi});
            wb(1'b0, `BSC_REG_CTRL, 32'h0, q);
            chk("ctrl", {23'h0, `BSC_CTRL_RST}, q);
            wb(1'b1, 8'h20, 32'hFFFFFFFF, q);
            wb(1'b0, 8'h20, 32'h0, q);
            chk("unmapped", 32'h0, q);
            $display("test reset done");
        end
    endtask
    task t_commute;
        integer c, k;
        reg [5:0] e;
        reg [2:0] seen;
        begin
            @(posedge clk);
            run_n <= 1'b0;
            for (c = 0; c < 16; c = c + 1) begin
                @(posedge clk);
                code <= c[2:0];
                rev  <= c[3];
                e = fwd_map(c[2:0]);
                if (c[3]) e = {e[2:0], e[5:3]};
                repeat (4) @(posedge clk);
                chk("upper", {29'h0, e[5:3]}, {29'h0, hi});
                seen = 3'h0;
                for (k = 0; k < 260; k = k + 1) begin
                    @(posedge clk);
                    seen = seen | lo;
                end
                chk("lower", {29'h0, e[2:0]}, {29'h0, seen});
            end
            $display("test commutation done");
        end
    endtask
    task t_halt;
        begin
            @(posedge clk);
            code <= 3'h5; rev <= 1'b0; run_n <= 1'b1;
            repeat (5) @(posedge clk);
            chk("halt upper", 32'h0, {29'h0, hi});
            chk("low power", 32'h1, {31'h0, lowp});
            run_n <= 1'b0;
            repeat (5) @(posedge clk);
            chk("run upper", 32'h1, {29'h0, hi});
            chk("run power", 32'h0, {31'h0, lowp});
            por <= 1'b1;
            repeat (5) @(posedge clk);
            chk("por upper", 32'h0, {29'h0, hi});
            por <= 1'b0;
            wb(1'b1, `BSC_REG_CTRL, 32'h1FF, q);
            repeat (4) @(posedge clk);
            chk("soft halt", 32'h0, {29'h0, hi});
            wb(1'b0, `BSC_REG_STATUS, 32'h0, q);
            chk("halt flag", 32'h1, {31'h0, q[1]});
            wb(1'b1, `BSC_REG_CTRL, 32'h0FF, q);
            repeat (4) @(posedge clk);
            chk("resume", 32'h1, {29'h0, hi});
            $display("test halt done");
        end
    endtask
    task t_lock;
        begin
            @(posedge clk);
            pin_hold <= 1'b0;
            n = 0;
            while (lock_n !== 1'b0 && n < 60000) begin
                @(posedge clk);
                n = n + 1;
            end
            chk("lock", 32'h0, {31'h0, lock_n});
            wb(1'b0, `BSC_REG_PERIOD, 32'h0, q);
            chk("period", 32'h4000, q);
            half <= 16'h0E00;
            n = 0;
            while (lock_n !== 1'b1 && n < 40000) begin
                @(posedge clk);
                n = n + 1;
            end
            repeat (16484) @(posedge clk);
            chk("unlock", 32'h1, {31'h0, lock_n});
            wb(1'b0, `BSC_REG_PERIOD, 32'h0, q);
            chk("fast period", 32'h3800, q);
            wb(1'b0, `BSC_REG_DUTY, 32'h0, q);
            chk("duty cut", 32'h1, {31'h0, q[7:0] < 8'hFF});
            $display("test lock done");
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_commute;
        t_halt;
        t_lock;
        final_report;
    end
    // Whole run needs about 64000 cycles, mostly the lock and unlock windows
    initial begin
        repeat (100000) @(posedge clk);
        fails = fails + 1;
        final_report;
    end
endmodule // testbench
bind bsc_ctrl bsc_ctrl_props i_props (.*);
